// [pkg/psc_pkg.sv]
// Function
// RULE1 - Power lamp steady when array power present
// RULE2 - Power lamp flashes while controller switched off
// RULE3 - Power lamp dark on insufficient power
// RULE4 - Run lamp steady at max, else duty
// RULE5 - Float lamp steady open, flashing during delay
// RULE6 - Pressure lamp steady over limit, flash delay
// RULE7 - Overload steady, slow on current, fast heat
// RULE8 - Start motor only with float closed
// RULE9 - Float opening stops motor, lights lamp
// RULE10 - Fifteen minute delay after float recloses
// RULE11 - On/off press aborts float delay
// RULE12 - First speed press only shows setting
// RULE13 - Further presses raise limit one step
// RULE14 - Full scale wraps to lowest step
// RULE15 - Hash ends entry, lone hash clears
// RULE16 - Star six hash sets voltage ceiling
// RULE17 - Keypad ceiling caps button speed limit
// RULE18 - Start lamp flashes until motor started
// RULE19 - Reopen during delay restarts full delay
// RULE20 - Flash and delay timing from prescaler
package psc_pkg;
  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int TICKS_PER_S = 256;
  localparam int TICK_NS = 1_000_000_000 / TICKS_PER_S;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // Synchroniser reset: float closed, buttons released
  localparam logic [2:0] PIN_SYNC_RST = 3'h1;
  // Float restart delay and speed display window
  localparam int FLOAT_DELAY_MIN = 15;
  localparam int FLOAT_DELAY_S = FLOAT_DELAY_MIN * 60;
  localparam int SPD_SHOW_S = 2;
  // Flash rates: bits of the phase counter
  localparam int SLOW_BIT = 7;
  localparam int FAST_BIT = 5;
  // Speed steps and voltage limits
  localparam logic [7:0] STEP_V = 8'h24;
  localparam logic [2:0] STEP_MIN = 3'h1;
  localparam logic [2:0] STEP_MAX = 3'h5;
  localparam logic [7:0] KP_V_MIN = 8'h24;
  localparam logic [7:0] KP_V_MAX = 8'hb4;
  localparam logic [7:0] SPEED_FULL = 8'hff;
  localparam logic [9:0] KP_ACC_SAT = 10'h3e7;
  // Keypad codes; digits are 0 to 9
  localparam logic [3:0] KEY_STAR = 4'ha;
  localparam logic [3:0] KEY_HASH = 4'hb;
  localparam logic [3:0] KEY_NINE = 4'h9;
  localparam logic [3:0] CMD_VLIM = 4'h6;
  localparam logic [3:0] CMD_NONE = 4'hf;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VLIM = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_FLT = 8'h0c;
  // Field positions
  localparam int CTRL_OFF_BIT = 0;
  localparam int STAT_FLT_LSB = 0;
  localparam int STAT_STEP_LSB = 4;
  localparam int STAT_EN_BIT = 7;
  localparam int STAT_VLIM_LSB = 8;
  localparam int STAT_ON_BIT = 16;
  // Conditions reported by the motor drive logic
  typedef struct packed {
    logic power_ok;
    logic started;
    logic [7:0] speed;
    logic press_over;
    logic press_delay;
    logic motor_ovl;
    logic curr_max;
    logic overheat;
  } psc_cond_s;
  // Float supervisor and keypad parser states
  typedef enum logic [1:0] {FL_OK, FL_OPEN, FL_DELAY} psc_float_e;
  typedef enum logic [1:0] {KP_IDLE, KP_STAR, KP_CMD, KP_VALUE} psc_kp_e;
endpackage

// [verilog/psc_top.sv]
`timescale 1ns/10ps
module psc_top #(
  parameter int TICK_CYC_P = psc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Panel pins, asynchronous
  input wire logic FLOAT_CLOSED,
  input wire logic ONOFF_BTN,
  input wire logic SPEED_BTN,
  // Drive conditions, same clock
  input wire psc_pkg::psc_cond_s COND,
  // Handheld keypad display, same clock
  input wire logic KEY_VALID,
  input wire logic [3:0] KEY_CODE,
  output logic DISP_PROMPT,
  output logic DISP_UPDATE,
  output logic [7:0] DISP_VOLT,
  // Status lamps
  output logic LAMP_POWER,
  output logic LAMP_RUN,
  output logic LAMP_FLOAT,
  output logic LAMP_PRESS,
  output logic LAMP_OVLD,
  output logic LAMP_START,
  // Motor command
  output logic MOTOR_ENABLE,
  output logic [7:0] SPEED_LIMIT
);
  import psc_pkg::*;

  // Voltage of a button step
  function automatic logic [7:0] step_volts(input logic [2:0] s);
    logic [10:0] p;
    p = 11'(s) * 11'(STEP_V);
    // Five steps at most, so the low byte holds it
    return p[7:0];
  endfunction

  // Pin synchronisers: stage one feeds stage two only
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_prev_q;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // Float reads closed in reset, so power-up starts no delay
      pin_s1_q <= PIN_SYNC_RST;
      pin_s2_q <= PIN_SYNC_RST;
      // Buttons idle low, so no false press follows reset
      pin_prev_q <= PIN_SYNC_RST;
    end else begin
      pin_s1_q <= {SPEED_BTN, ONOFF_BTN, FLOAT_CLOSED};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  // Level of the float contacts after the synchroniser
  wire float_closed = pin_s2_q[0];
  // Presses are rising edges of the synchronised buttons
  wire onoff_press = pin_s2_q[1] & ~pin_prev_q[1];
  wire speed_press = pin_s2_q[2] & ~pin_prev_q[2];

  // Prescaler: one tick per 1/256 s, phase counts ticks
  // Wide enough for the full default tick period
  logic [16:0] pre_q;
  // Phase wraps once a second and drives every flash
  logic [7:0] phase_q;
  // Tick ends each prescaler period
  wire tick = (pre_q == 17'(TICK_CYC_P - 1)); // RULE20
  // Whole second when the phase wraps
  wire sec_tick = tick & (phase_q == 8'hff);
  // Prescaler and phase advance together
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_q <= 17'h0;
      phase_q <= 8'h0;
    end else begin
      pre_q <= tick ? 17'h0 : pre_q + 17'h1;
      phase_q <= tick ? phase_q + 8'h1 : phase_q;
    end
  end
  // Slow is 1 Hz, fast is 4 Hz
  wire flash_slow = phase_q[SLOW_BIT]; // RULE20
  wire flash_fast = phase_q[FAST_BIT]; // RULE20

  // On/off state; software may also hold the unit off
  logic sw_on_q;
  // Remote off bit, held in the control register
  logic remote_off_q;
  // Either source alone turns the unit off
  wire unit_on = sw_on_q & ~remote_off_q;
  // Each press toggles; reset leaves the unit on
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) sw_on_q <= 1'b1;
    else if (onoff_press) sw_on_q <= ~sw_on_q;
  end

  // Float supervisor
  psc_float_e flt_q, flt_d;
  // Seconds left in the restart delay
  logic [9:0] flt_left_q, flt_left_d;
  // Delay done once the count reaches zero
  wire flt_expire = (flt_left_q == 10'h0);
  // Next state of the float supervisor
  always_comb begin
    flt_d = flt_q;
    flt_left_d = flt_left_q;
    unique case (flt_q)
      FL_OK: begin
        // Opening stops at once
        if (!float_closed) flt_d = FL_OPEN; // RULE9
      end
      FL_OPEN: begin
        // Reclose arms the full delay
        if (float_closed) begin
          flt_d = FL_DELAY; // RULE10
          flt_left_d = 10'(FLOAT_DELAY_S); // RULE19
        end
      end
      FL_DELAY: begin
        // Reopening wins over a press and over expiry
        if (!float_closed) flt_d = FL_OPEN; // RULE19
        else if (onoff_press) flt_d = FL_OK; // RULE11
        else if (flt_expire) flt_d = FL_OK; // RULE10
        else if (sec_tick) flt_left_d = flt_left_q - 10'h1; // RULE10
      end
    endcase
  end
  // Float state flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flt_q <= FL_OK;
      flt_left_q <= 10'h0;
    end else begin
      flt_q <= flt_d;
      flt_left_q <= flt_left_d;
    end
  end

  // Keypad ceiling, written by keypad or bus
  // Resets to full scale so buttons alone reach the top
  logic [7:0] vlim_q;

  // Speed button: first press shows, later presses step
  logic [2:0] step_q, step_d;
  // Second ticks left in the display window
  logic [1:0] show_q, show_d;
  // Window open while the count is nonzero
  wire show_on = (show_q != 2'h0);
  // Wrap at full scale or once the ceiling is reached
  wire step_top = (step_q >= STEP_MAX) | (step_volts(step_q) >= vlim_q); // RULE14 RULE17
  wire [2:0] step_next = step_top ? STEP_MIN : step_q + 3'h1; // RULE13 RULE14
  // Next step and window count
  always_comb begin
    step_d = step_q;
    show_d = show_q;
    if (speed_press) begin
      show_d = 2'(SPD_SHOW_S);
      // Only a press inside the window changes the step
      if (show_on) step_d = step_next; // RULE12 RULE13
    end else if (sec_tick && show_on) begin
      show_d = show_q - 2'h1;
    end
  end
  // Step resets to full scale
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      step_q <= STEP_MAX;
      show_q <= 2'h0;
    end else begin
      step_q <= step_d;
      show_q <= show_d;
    end
  end
  // Effective limit never exceeds the keypad ceiling
  wire [7:0] btn_v = step_volts(step_q);
  wire [7:0] eff_v = (btn_v > vlim_q) ? vlim_q : btn_v; // RULE17

  // Keypad parser
  psc_kp_e kp_q, kp_d;
  // Command digit after the star
  logic [3:0] cmd_q, cmd_d;
  // Decimal value being entered
  logic [9:0] acc_q, acc_d;
  // One-cycle load and display strobes
  logic kp_load, kp_upd;
  // Digit keys are the codes up to nine
  wire key_digit = (KEY_CODE <= KEY_NINE);
  // Shift in one digit; saturation keeps the value narrow
  wire [13:0] acc_mul = 14'(acc_q) * 14'h0a + 14'(KEY_CODE);
  wire [9:0] acc_next = (acc_mul > 14'(KP_ACC_SAT)) ? KP_ACC_SAT : acc_mul[9:0];
  // Ceiling accepted only inside the voltage bounds
  wire acc_ok = (acc_q >= 10'(KP_V_MIN)) & (acc_q <= 10'(KP_V_MAX));
  // Keypad next state
  always_comb begin
    kp_d = kp_q;
    cmd_d = cmd_q;
    acc_d = acc_q;
    kp_load = 1'b0;
    kp_upd = 1'b0;
    if (KEY_VALID) begin
      if (KEY_CODE == KEY_STAR) begin
        // Star always begins a fresh command
        kp_d = KP_STAR;
        cmd_d = CMD_NONE;
      end else begin
        unique case (kp_q)
          KP_IDLE: begin
            kp_d = KP_IDLE; // RULE15
          end
          KP_STAR, KP_CMD: begin
            if (key_digit) begin
              // Only a single digit names a command here
              cmd_d = (kp_q == KP_STAR) ? KEY_CODE : CMD_NONE;
              kp_d = KP_CMD;
            end else if (KEY_CODE == KEY_HASH) begin
              // Hash ends the command; unknown ones clear
              kp_d = (kp_q == KP_CMD && cmd_q == CMD_VLIM) ? KP_VALUE : KP_IDLE; // RULE15 RULE16
              acc_d = 10'h0;
            end else begin
              kp_d = KP_IDLE;
            end
          end
          KP_VALUE: begin
            if (key_digit) begin
              acc_d = acc_next; // RULE16
            end else if (KEY_CODE == KEY_HASH) begin
              // Out of range keeps old ceiling, still shown
              kp_load = acc_ok; // RULE16
              kp_upd = 1'b1; // RULE16
              kp_d = KP_IDLE; // RULE15
            end else begin
              kp_d = KP_IDLE;
            end
          end
        endcase
      end
    end
  end
  // Keypad parser flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      kp_q <= KP_IDLE;
      cmd_q <= CMD_NONE;
      acc_q <= 10'h0;
    end else begin
      kp_q <= kp_d;
      cmd_q <= cmd_d;
      acc_q <= acc_d;
    end
  end

  // APB decode; one wait-free access after setup
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
  // Register decode on the byte address
  wire hit_ctrl = (PADDR == REG_CTRL);
  wire hit_vlim = (PADDR == REG_VLIM);
  wire hit_stat = (PADDR == REG_STAT);
  wire hit_flt = (PADDR == REG_FLT);
  wire hit_any = hit_ctrl | hit_vlim | hit_stat | hit_flt;
  // Written ceiling is the low byte
  wire [7:0] wr_v = PWDATA[7:0];
  wire wr_v_ok = (wr_v >= KP_V_MIN) & (wr_v <= KP_V_MAX);
  // Motor permitted only with power, unit on and float clear
  wire en_d = COND.power_ok & unit_on & (flt_q == FL_OK); // RULE8
  // Status word shows the block's own state
  wire [31:0] stat_w = (32'(flt_q) << STAT_FLT_LSB) | (32'(step_q) << STAT_STEP_LSB)
                     | (32'(en_d) << STAT_EN_BIT) | (32'(eff_v) << STAT_VLIM_LSB)
                     | (32'(unit_on) << STAT_ON_BIT);
  wire [31:0] rd_w = hit_ctrl ? 32'(remote_off_q) << CTRL_OFF_BIT :
                     hit_vlim ? 32'(vlim_q) :
                     hit_stat ? stat_w :
                     hit_flt ? 32'(flt_left_q) : 32'h0;

  // Bus response flops
  // Ready follows setup by one cycle; no wait states
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~hit_any;
      PRDATA <= (apb_setup & ~PWRITE) ? rd_w : 32'h0;
    end
  end

  // Control registers; keypad wins over a bus write
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      remote_off_q <= 1'b0;
      vlim_q <= KP_V_MAX;
    end else begin
      if (apb_wr && hit_ctrl) remote_off_q <= PWDATA[CTRL_OFF_BIT];
      if (kp_load) vlim_q <= acc_q[7:0]; // RULE17
      else if (apb_wr && hit_vlim && wr_v_ok) vlim_q <= wr_v;
    end
  end

  // Lamp selection
  // Power: dark beats flashing beats steady
  wire l_pow = !COND.power_ok ? 1'b0 : // RULE3
               !unit_on ? flash_slow : // RULE2
               1'b1; // RULE1
  // Run: steady at full speed, else duty from speed
  wire run_duty = (phase_q < COND.speed); // RULE4
  wire l_run = COND.started & ((COND.speed == SPEED_FULL) | run_duty); // RULE4 RULE18
  // Float: steady while open, flashing in delay
  wire l_flt = (flt_q == FL_OPEN) | ((flt_q == FL_DELAY) & flash_slow); // RULE5 RULE9
  // Pressure: steady over limit, flashing in delay
  wire l_prs = COND.press_over | (COND.press_delay & flash_slow); // RULE6
  // Overload: motor overload first, then heat, then current
  wire l_ovl = COND.motor_ovl ? 1'b1 : // RULE7
               COND.overheat ? flash_fast : // RULE7
               COND.curr_max & flash_slow; // RULE7
  // Start: flashing while enabled and not yet started
  wire l_start = en_d & ~COND.started & flash_slow; // RULE18
  // Speed window shows the step as a bar of lamps
  wire [4:0] bar;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_bar
      assign bar[gi] = (step_q > 3'(gi)); // RULE12
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LAMP_POWER <= 1'b0;
      LAMP_RUN <= 1'b0;
      LAMP_FLOAT <= 1'b0;
      LAMP_PRESS <= 1'b0;
      LAMP_OVLD <= 1'b0;
      LAMP_START <= 1'b0;
      MOTOR_ENABLE <= 1'b0;
      SPEED_LIMIT <= 8'h0;
    end else begin
      // Speed window borrows the first five lamps
      LAMP_POWER <= show_on ? bar[0] : l_pow;
      LAMP_RUN <= show_on ? bar[1] : l_run;
      LAMP_FLOAT <= show_on ? bar[2] : l_flt;
      LAMP_PRESS <= show_on ? bar[3] : l_prs;
      LAMP_OVLD <= show_on ? bar[4] : l_ovl;
      // Start lamp is never borrowed
      LAMP_START <= l_start;
      MOTOR_ENABLE <= en_d; // RULE8 RULE9
      SPEED_LIMIT <= eff_v; // RULE17
    end
  end

  // Keypad display outputs
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DISP_PROMPT <= 1'b0;
      DISP_UPDATE <= 1'b0;
      DISP_VOLT <= 8'h0;
    end else begin
      // Prompt follows the next state, so it rises with the hash
      DISP_PROMPT <= (kp_d == KP_VALUE); // RULE16
      DISP_UPDATE <= kp_upd; // RULE16
      if (kp_upd) DISP_VOLT <= kp_load ? acc_q[7:0] : vlim_q;
    end
  end
endmodule

// [bench/psc_properties.sv]
`timescale 1ns/10ps
module psc_properties
  import psc_pkg::*;
#(
  parameter int TICK_CYC_P = psc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Bus handshake
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  // Pins and drive conditions
  input wire logic FLOAT_CLOSED,
  input wire logic SPEED_BTN,
  input wire psc_pkg::psc_cond_s COND,
  input wire logic KEY_VALID,
  input wire logic [3:0] KEY_CODE,
  // Outputs watched
  input wire logic DISP_PROMPT,
  input wire logic DISP_UPDATE,
  input wire logic LAMP_POWER,
  input wire logic LAMP_RUN,
  input wire logic LAMP_FLOAT,
  input wire logic LAMP_PRESS,
  input wire logic LAMP_OVLD,
  input wire logic MOTOR_ENABLE,
  input wire logic [7:0] SPEED_LIMIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // The speed window borrows the lamps for up to two seconds after a press
  localparam int WIN_CYC = (SPD_SHOW_S + 1) * TICKS_PER_S * TICK_CYC_P + 8;
  int win_cnt;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) win_cnt <= 0;
    else if (SPEED_BTN) win_cnt <= WIN_CYC;
    else if (win_cnt != 0) win_cnt <= win_cnt - 1;
  end
  wire win_open = (win_cnt != 0);
  // Voltage limit command on back-to-back strobes
  sequence s_vlim_cmd;
    (KEY_VALID && KEY_CODE == KEY_STAR) ##1 (KEY_VALID && KEY_CODE == CMD_VLIM)
      ##1 (KEY_VALID && KEY_CODE == KEY_HASH);
  endsequence
  a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_power_dark: assert property (!COND.power_ok && !win_open |=> !LAMP_POWER)
    else $error("power lamp lit without power");
  a_run_full: assert property (!win_open && COND.started && COND.speed == SPEED_FULL
    |=> LAMP_RUN)
    else $error("run lamp not steady at full speed");
  a_run_stopped: assert property (!COND.started && !win_open |=> !LAMP_RUN)
    else $error("run lamp lit before start");
  a_press_steady: assert property (COND.press_over && !win_open |=> LAMP_PRESS)
    else $error("pressure lamp not lit");
  a_ovld_steady: assert property (COND.motor_ovl && !win_open |=> LAMP_OVLD)
    else $error("overload lamp not lit");
  // Two sync flops plus state leave the pin some cycles of lag
  a_float_stop: assert property (!FLOAT_CLOSED [*6] |-> !MOTOR_ENABLE && (win_open || LAMP_FLOAT))
    else $error("motor enabled with float open");
  a_prompt_up: assert property (s_vlim_cmd |=> DISP_PROMPT)
    else $error("no prompt after limit command");
  a_star_clear: assert property (KEY_VALID && KEY_CODE == KEY_STAR |=> !DISP_PROMPT)
    else $error("prompt survives new command");
  a_update_pulse: assert property (DISP_UPDATE |=> !DISP_UPDATE)
    else $error("update longer than one cycle");
  a_limit_top: assert property (SPEED_LIMIT <= KP_V_MAX)
    else $error("limit above full scale");
endmodule

bind psc_top psc_properties #(.TICK_CYC_P(TICK_CYC_P)) u_props (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .FLOAT_CLOSED(FLOAT_CLOSED), .SPEED_BTN(SPEED_BTN), .COND(COND), .KEY_VALID(KEY_VALID),
  .KEY_CODE(KEY_CODE),
  .DISP_PROMPT(DISP_PROMPT), .DISP_UPDATE(DISP_UPDATE), .LAMP_POWER(LAMP_POWER),
  .LAMP_RUN(LAMP_RUN), .LAMP_FLOAT(LAMP_FLOAT), .LAMP_PRESS(LAMP_PRESS),
  .LAMP_OVLD(LAMP_OVLD), .MOTOR_ENABLE(MOTOR_ENABLE), .SPEED_LIMIT(SPEED_LIMIT));

// [bench/psc_panel_model.sv]
`timescale 1ns/10ps
module psc_panel_model (
  // Clock
  input wire logic clk,
  // Panel pins
  output logic float_closed,
  output logic onoff_btn,
  output logic speed_btn,
  // Keypad strobe
  output logic key_valid,
  output logic [3:0] key_code
);
  // Contacts closed and nothing pressed at power-up
  initial begin
    float_closed = 1'b1;
    onoff_btn = 1'b0;
    speed_btn = 1'b0;
    key_valid = 1'b0;
    key_code = 4'h0;
  end
  // Float contacts open or close
  task flt(input logic cl);
    @(posedge clk);
    float_closed <= cl;
  endtask
  // Held long enough for the synchroniser
  task press(input logic spd);
    @(posedge clk);
    if (spd) speed_btn <= 1'b1;
    else onoff_btn <= 1'b1;
    repeat (4) @(posedge clk);
    speed_btn <= 1'b0;
    onoff_btn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // One key per edge; hash ends every entry
  task key(input logic [3:0] k);
    @(posedge clk);
    key_valid <= 1'b1;
    key_code <= k;
  endtask
  // Code inverted on release so stale data never looks valid
  task kdone;
    @(posedge clk);
    key_valid <= 1'b0;
    key_code <= ~key_code;
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb;
  import psc_pkg::*;
  // Bench signals
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e, v;
  logic [7:0] paddr = 0, dv, lim;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, fl, onb, spb, kv, dp, du, men;
  logic [3:0] kc;
  logic [5:0] lamps;
  psc_cond_s cond, c;
  int error_cnt = 0, samples_checked = 0, n;
  always #25 clk = ~clk;
  // Tick of one cycle keeps a second at 256 cycles
  psc_top #(.TICK_CYC_P(1)) dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FLOAT_CLOSED(fl), .ONOFF_BTN(onb), .SPEED_BTN(spb), .COND(cond),
    .KEY_VALID(kv), .KEY_CODE(kc), .DISP_PROMPT(dp), .DISP_UPDATE(du), .DISP_VOLT(dv),
    .LAMP_POWER(lamps[0]), .LAMP_RUN(lamps[1]), .LAMP_FLOAT(lamps[2]), .LAMP_PRESS(lamps[3]),
    .LAMP_OVLD(lamps[4]), .LAMP_START(lamps[5]), .MOTOR_ENABLE(men), .SPEED_LIMIT(lim));
  psc_panel_model pm (.clk(clk), .float_closed(fl), .onoff_btn(onb), .speed_btn(spb),
    .key_valid(kv), .key_code(kc));
  // Bus cycle; request held until ready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task setc;
    @(posedge clk);
    cond <= c;
    wt(3);
  endtask
  // Edge count n and last level v of one lamp over a slow period
  task watch(input int i);
    // Let the last change reach the lamp flops first
    wt(2);
    n = 0;
    v = lamps[i];
    repeat (256) begin
      wt(1);
      if (lamps[i] !== v) n++;
      v = lamps[i];
    end
  endtask
  task t_regs;
    apb(0, REG_VLIM, 0);
    `CHK(r, 32'hb4)
    apb(0, 8'hf0, 0);
    `CHK({e, r}, 33'h100000000)
    apb(1, REG_VLIM, 32'hffffff10);
    apb(0, REG_VLIM, 0);
    `CHK(r, 32'hb4)
    apb(1, REG_CTRL, 1);
    watch(0);
    `CHK(n > 0, 1'b1)
    apb(0, REG_STAT, 0);
    `CHK(r[16], 1'b0)
    apb(1, REG_CTRL, 0);
    watch(0);
    `CHK({n == 0, v}, 2'b11)
  endtask
  task t_lamps;
    watch(5);
    `CHK(n > 0, 1'b1)
    c.started = 1;
    c.speed = 8'hff;
    setc;
    watch(1);
    `CHK({n == 0, v, lamps[5]}, 3'b110)
    c.speed = 8'h80;
    setc;
    watch(1);
    `CHK(n > 0, 1'b1)
    c.press_delay = 1;
    setc;
    watch(3);
    `CHK(n > 0, 1'b1)
    c.curr_max = 1;
    setc;
    watch(4);
    `CHK(n > 0 && n < 4, 1'b1)
    c.overheat = 1;
    setc;
    watch(4);
    `CHK(n > 5, 1'b1)
    c.motor_ovl = 1;
    c.press_over = 1;
    setc;
    watch(4);
    `CHK({n == 0, v, lamps[3]}, 3'b111)
    c.power_ok = 0;
    setc;
    `CHK(lamps[0], 1'b0)
    c = '0;
    c.power_ok = 1;
    setc;
  endtask
  task t_float;
    pm.flt(0);
    wt(8);
    `CHK({men, lamps[2]}, 2'b01)
    pm.flt(1);
    wt(8);
    apb(0, REG_STAT, 0);
    `CHK({r[1:0], men}, 3'b100)
    watch(2);
    `CHK(n > 0, 1'b1)
    apb(0, REG_FLT, 0);
    `CHK(r[9:0] < 10'h384, 1'b1)
    pm.flt(0);
    wt(8);
    apb(0, REG_STAT, 0);
    `CHK(r[1:0], 2'h1)
    pm.flt(1);
    wt(8);
    pm.press(0);
    apb(0, REG_STAT, 0);
    `CHK(r[1:0], 2'h0)
    pm.press(0);
  endtask
  task t_speed;
    `CHK(lim, 8'hb4)
    pm.press(1);
    `CHK(lim, 8'hb4)
    pm.press(1);
    `CHK(lim, 8'h24)
    pm.press(1);
    `CHK(lim, 8'h48)
  endtask
  // Voltage ceiling entry of three digits; the shown ceiling must read 100 after it
  task entry(input logic [3:0] a, input logic [3:0] b);
    pm.key(KEY_STAR);
    pm.key(CMD_VLIM);
    pm.key(KEY_HASH);
    pm.kdone;
    #1;
    `CHK(dp, 1'b1)
    pm.key(a);
    pm.key(b);
    pm.key(4'h0);
    pm.key(KEY_HASH);
    pm.kdone;
    #1;
    `CHK({du, dv}, 9'h164)
  endtask
  task t_keypad;
    pm.key(KEY_HASH);
    pm.kdone;
    entry(4'h1, 4'h0);
    wt(2);
    `CHK(lim, 8'h48)
    pm.press(1);
    `CHK(lim, 8'h64)
    pm.press(1);
    `CHK(lim, 8'h24)
    entry(4'h2, 4'h0);
  endtask
  task stop_test;
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    c = '0;
    c.power_ok = 1;
    cond = c;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_lamps;
    t_float;
    t_speed;
    t_keypad;
    stop_test;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule
